// ==== rtl/ssr_pkg.sv ====
// package for the serial status readback block
// shared by the design and the bench; no clocks or processes here
package ssr_pkg;

  // command word fields
  localparam int WORD_BITS     = 8;   // one serial byte
  localparam int CMD_CH_BIT    = 7;   // channel / watchdog bit
  localparam int CMD_ADDR_HI   = 6;   // address field top
  localparam int CMD_ADDR_LO   = 4;   // address field bottom
  localparam int CNT_W         = 16;  // received bit counter width

  // command addresses (bits 6:4 of a command)
  localparam logic [2:0] ADDR_STATUS_SEL = 3'h0;
  localparam logic [2:0] ADDR_OUT_CTRL   = 3'h1;
  localparam logic [2:0] ADDR_OC_LEVEL   = 3'h2;
  localparam logic [2:0] ADDR_BLANK_OL   = 3'h3;
  localparam logic [2:0] ADDR_DIRECT_IN  = 3'h4;
  localparam logic [2:0] ADDR_DLY_WD     = 3'h5;
  localparam logic [2:0] ADDR_PIN_SUPPLY = 3'h6;
  localparam logic [2:0] ADDR_NULL       = 3'h7;

  // reset values
  localparam logic [7:0] RST_CMD  = 8'h00;
  localparam logic [2:0] RST_SEL  = 3'h7;  // null readback until selected
  localparam logic [3:0] RST_NIB  = 4'h0;

  // low trip codes: 000 = 25 A ... 111 = 7.5 A; high bit: 0 = 100 A, 1 = 75 A
  // blank codes: 00 155 ms, 01 10 ms, 10 1.2 ms, 11 150 us
  // watchdog codes: 00 620 ms, 01 310 ms, 10 2500 ms, 11 1250 ms

  // fault inputs of one channel
  typedef struct packed {
    logic overtemp;
    logic oc_high;
    logic oc_low;
    logic open_load;
  } ssr_chan_fault_s;

  // per-channel configuration nibbles
  typedef struct packed {
    logic [3:0] oc_level;    // high_trip_bit, low_trip_code
    logic [3:0] blank_ol;    // openload_disable, timeout_disable, blank_time_code
    logic [3:0] direct_in;   // fast slew, high ratio, input disable, and/or
  } ssr_chan_cfg_s;

  // whole state of the block
  typedef struct packed {
    logic [2:0]       sclk_sync;   // two sync stages plus previous level
    logic [2:0]       cs_sync;
    logic [1:0]       si_sync;
    logic             in_frame;
    logic [CNT_W-1:0] bit_cnt;
    logic [7:0]       rx_shift;    // last eight bits received, not cleared at frame start
    logic [7:0]       tx_shift;    // bits still to send
    logic             so_bit;
    logic             so_oe;
    logic [7:0]       prev_cmd;    // last valid command
    logic [2:0]       status_sel;  // last written status select
    logic             sel_ch;      // channel stored with the select
    logic [3:0]       out_ctrl;    // sense1, on1, sense0, on0
    ssr_chan_cfg_s [1:0] cfg;
    logic [2:0]       delay_code;
    logic [1:0]       wd_period;
    logic [1:0]       supply_off;  // undervolt_prot_off, overvolt_prot_off
    ssr_chan_fault_s [1:0] flt_hold; // sticky faults, frozen in frame
    logic [1:0]       supply_hold;  // undervoltage, overvoltage
    logic             summary_flt;
    logic             fault_pin;
  } ssr_state_s;

endpackage : ssr_pkg

// ==== rtl/ssr_status_readback.sv ====
// serial status return path of a dual protected switch
// assumes an external master drives chip select, clock and data pins
// asynchronous to clk_sys_in; pins are synchronised here
//
// Notes on behaviour
// - cs fall loads status, shifted msb first
// - after first byte, echo input delayed byte
// - latch only on nonzero multiple of eight
// - cs high: release so, faults update again
// - invalid frame discarded, status unchanged
// - status bit seven echoes previous channel bit
// - status select persists until rewritten
// - address 000 returns selected channel faults
// - summary fault set by either, read clears
// - latched faults hold pin until switch on
// - address 001 returns sense and on bits
// - address 010 returns trip levels
// - address 011 returns blanking and disables
// - address 100 returns direct input config
// - address 101 ch0 returns delay, failsafe0
// - address 101 ch1 returns watchdog, failsafe1
// - address 110 ch0 returns live pin levels
// - address 110 ch1 returns supply disables
// - address 111 returns null low bits
// - trip codes stored as programmed codes
// - blanking codes stored as programmed codes
// - watchdog codes stored as programmed codes
`timescale 1ns/1ps

module ssr_status_readback
  import ssr_pkg::*;
(
  input  wire logic                 clk_sys_in,       // 10 MHz system clock
  input  wire logic                 sys_rst_in,       // synchronous reset, high
  input  wire logic                 sclk_in,          // serial clock pin
  input  wire logic                 cs_n_in,          // chip select pin, low active
  input  wire logic                 si_in,            // serial data in pin
  output logic                      so_out,           // serial data out
  output logic                      so_oe_out,        // so drive enable
  input  wire ssr_pkg::ssr_chan_fault_s [1:0] chan_fault_in, // fault events per channel
  input  wire logic                 undervoltage_in,  // supply under limit
  input  wire logic                 overvoltage_in,   // supply over limit
  input  wire logic                 direct_on_in,     // switch-on via direct input
  input  wire logic                 in1_pin_in,       // live input pin 1
  input  wire logic                 in0_pin_in,       // live input pin 0
  input  wire logic                 failsafe_select_pin_in, // fail-safe select pin
  input  wire logic                 wake_pin_in,      // wake pin
  input  wire logic                 watchdog_expired_in, // device in fail-safe
  input  wire logic [1:0]           failsafe_state_in,   // fail-safe state per channel
  output logic                      fault_indicator_pin_out, // fault pin level
  output logic [7:0]                last_cmd_out      // last valid command word
);
  import ssr_pkg::*;

  ssr_state_s st;       // registered state
  ssr_state_s next_st;  // next state

  // combinational helpers
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_fall;
  logic       cs_rise;
  logic [7:0] status_word;
  logic [3:0] low_nib;
  logic       ch;
  logic [7:0] cmd;
  logic       valid;
  logic       any_fault;
  logic       switch_on;

  // edge detection on the second and third sync stages only
  always_comb
  begin
    sclk_rise = st.sclk_sync[1] & ~st.sclk_sync[2];
    sclk_fall = ~st.sclk_sync[1] & st.sclk_sync[2];
    cs_fall   = ~st.cs_sync[1] & st.cs_sync[2];
    cs_rise   = st.cs_sync[1] & ~st.cs_sync[2];
  end

  // status word built from previous command and stored selection
  always_comb
  begin
    ch      = st.prev_cmd[CMD_CH_BIT];
    low_nib = 4'h0;
    // readbacks 010 to 100 use the channel stored with the select write; 101 and 110 use the previous command's channel bit
    case (st.status_sel)
      ADDR_STATUS_SEL: low_nib = 4'h0;
      ADDR_OUT_CTRL:   low_nib = st.out_ctrl;
      ADDR_OC_LEVEL:   low_nib = st.cfg[st.sel_ch].oc_level;
      ADDR_BLANK_OL:   low_nib = st.cfg[st.sel_ch].blank_ol;
      ADDR_DIRECT_IN:  low_nib = st.cfg[st.sel_ch].direct_in;
      ADDR_DLY_WD:
      begin
        if (!ch)
          low_nib = {failsafe_state_in[0], st.delay_code};
        else
          low_nib = {failsafe_state_in[1], watchdog_expired_in, st.wd_period};
      end
      ADDR_PIN_SUPPLY:
      begin
        if (!ch)
          low_nib = {in1_pin_in, in0_pin_in, failsafe_select_pin_in, wake_pin_in};
        else
          low_nib = {2'h0, st.supply_off};
      end
      default:         low_nib = 4'h0;
    endcase
    if (st.status_sel == ADDR_STATUS_SEL)
      status_word = {ch, st.flt_hold[st.sel_ch].overtemp, st.flt_hold[st.sel_ch].oc_high,
                     st.flt_hold[st.sel_ch].oc_low, st.flt_hold[st.sel_ch].open_load,
                     st.supply_hold, st.summary_flt};
    else
      status_word = {ch, st.status_sel, low_nib};
  end

  // next-state logic
  always_comb
  begin
    next_st = st;
    cmd     = st.rx_shift;
    valid   = 1'b0;
    // two-stage synchronisers plus edge history
    next_st.sclk_sync = {st.sclk_sync[1:0], sclk_in};
    next_st.cs_sync   = {st.cs_sync[1:0], cs_n_in};
    next_st.si_sync   = {st.si_sync[0], si_in};
    // fault capture only outside frames; sticky until reset, overcurrent bits reloaded on switch-on
    any_fault = (|chan_fault_in[0]) | (|chan_fault_in[1])
                | (undervoltage_in & ~st.supply_off[1])
                | (overvoltage_in & ~st.supply_off[0]);
    switch_on = direct_on_in;
    if (!st.in_frame)
    begin
      next_st.flt_hold[0]  = st.flt_hold[0] | chan_fault_in[0];
      next_st.flt_hold[1]  = st.flt_hold[1] | chan_fault_in[1];
      next_st.supply_hold  = st.supply_hold
                             | ({undervoltage_in, overvoltage_in} & ~st.supply_off);
    end
    if (cs_fall)
    begin
      // frame opens: load status, count from zero
      next_st.in_frame = 1'b1;
      next_st.bit_cnt  = '0;
      next_st.tx_shift = status_word;
      next_st.so_bit   = status_word[7];
      next_st.so_oe    = 1'b1;
      if (st.status_sel == ADDR_STATUS_SEL)
        next_st.summary_flt = 1'b0;
    end
    else if (st.in_frame && cs_rise)
    begin
      // frame closes: release so, judge length
      next_st.in_frame = 1'b0;
      next_st.so_oe    = 1'b0;
      valid = (st.bit_cnt != '0) && (st.bit_cnt[2:0] == 3'h0);
      if (valid)
      begin
        next_st.prev_cmd = cmd;
        case (cmd[CMD_ADDR_HI:CMD_ADDR_LO])
          ADDR_STATUS_SEL:
          begin
            next_st.status_sel = cmd[2:0];
            next_st.sel_ch     = cmd[CMD_CH_BIT];
          end
          ADDR_OUT_CTRL:
          begin
            next_st.out_ctrl = cmd[3:0];
            if (cmd[0] | cmd[2])
              switch_on = 1'b1;
          end
          ADDR_OC_LEVEL:   next_st.cfg[cmd[CMD_CH_BIT]].oc_level  = cmd[3:0];
          ADDR_BLANK_OL:   next_st.cfg[cmd[CMD_CH_BIT]].blank_ol  = cmd[3:0];
          ADDR_DIRECT_IN:  next_st.cfg[cmd[CMD_CH_BIT]].direct_in = cmd[3:0];
          ADDR_DLY_WD:
          begin
            if (!cmd[CMD_CH_BIT])
              next_st.delay_code = cmd[2:0];
            else
              next_st.wd_period = cmd[1:0];
          end
          ADDR_PIN_SUPPLY:
          begin
            if (cmd[CMD_CH_BIT])
              next_st.supply_off = cmd[1:0];
          end
          default:         next_st.prev_cmd = cmd; // test address: no write
        endcase
      end
      // an invalid frame only clears in_frame and so_oe; no command or config register is written
    end
    else if (st.in_frame)
    begin
      if (sclk_rise)
      begin
        // sample si on the rising edge
        next_st.rx_shift = {st.rx_shift[6:0], st.si_sync[1]};
        next_st.bit_cnt  = st.bit_cnt + CNT_W'(1);
      end
      if (sclk_fall && st.bit_cnt != '0)
      begin
        // shift on the falling edge; received byte follows status
        if (st.bit_cnt[2:0] == 3'h0)
        begin
          next_st.tx_shift = st.rx_shift;
          next_st.so_bit   = st.rx_shift[7];
        end
        else
        begin
          next_st.tx_shift = {st.tx_shift[6:0], 1'b0};
          next_st.so_bit   = st.tx_shift[6];
        end
      end
    end
    // summary flag set by any fault outside a frame, set wins over read clear
    if (any_fault && !st.in_frame)
      next_st.summary_flt = 1'b1;
    // latched faults hold the pin until a switch-on command or direct input
    if (any_fault)
      next_st.fault_pin = 1'b1;
    else if (switch_on)
      next_st.fault_pin = 1'b0;
    if (switch_on)
    begin
      next_st.flt_hold[0].oc_high = chan_fault_in[0].oc_high;
      next_st.flt_hold[0].oc_low  = chan_fault_in[0].oc_low;
      next_st.flt_hold[1].oc_high = chan_fault_in[1].oc_high;
      next_st.flt_hold[1].oc_low  = chan_fault_in[1].oc_low;
    end
  end

  // state register
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      st            <= '0;
      st.sclk_sync  <= 3'h0;
      st.cs_sync    <= 3'h7;
      st.prev_cmd   <= RST_CMD;
      st.status_sel <= RST_SEL;
      st.out_ctrl   <= RST_NIB;
    end
    else
      st <= next_st;
  end

  // outputs straight from flops
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      so_out                  <= 1'b0;
      so_oe_out               <= 1'b0;
      fault_indicator_pin_out <= 1'b0;
      last_cmd_out            <= RST_CMD;
    end
    else
    begin
      so_out                  <= next_st.so_bit;
      so_oe_out               <= next_st.so_oe;
      fault_indicator_pin_out <= next_st.fault_pin;
      last_cmd_out            <= next_st.prev_cmd;
    end
  end

endmodule // ssr_status_readback

// ==== verif/ssr_monitor.sv ====
// checker for the serial status readback ports
// bound to every ssr_status_readback; sees top ports only
`timescale 1ns/1ps

module ssr_monitor
  import ssr_pkg::*;
(
  input wire logic                           clk_sys_in,
  input wire logic                           sys_rst_in,
  input wire logic                           sclk_in,
  input wire logic                           cs_n_in,
  input wire logic                           so_out,
  input wire logic                           so_oe_out,
  input wire ssr_pkg::ssr_chan_fault_s [1:0] chan_fault_in,
  input wire logic                           fault_indicator_pin_out,
  input wire logic [7:0]                     last_cmd_out
);
  // one clock domain, reset aborts every attempt
  default clocking dc @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  // select held low six cycles: so must be driven by then
  AST_OE_RISE: assert property ($fell(cs_n_in) ##1 !cs_n_in [*5] |-> so_oe_out)
    else $error("so not driven after select fell");
  // drive only starts from a low select
  AST_OE_CAUSE: assert property ($rose(so_oe_out) |-> !$past(cs_n_in, 2))
    else $error("so driven without select");
  // drive holds while select stays low
  AST_OE_HOLD: assert property (so_oe_out && !cs_n_in |=> so_oe_out)
    else $error("so released inside frame");
  // select high for six cycles: line released
  AST_OE_QUIET: assert property (cs_n_in [*6] |-> !so_oe_out)
    else $error("so still driven after select rose");
  // serial clock high for a while: output bit must not move
  AST_SO_STABLE: assert property (so_oe_out && $past(so_oe_out) && sclk_in && $past(sclk_in)
    && $past(sclk_in, 2) && $past(sclk_in, 3) |-> $stable(so_out))
    else $error("so changed while serial clock high");
  // first bit out is the channel bit of the previous command
  AST_FIRST_BIT: assert property ($rose(so_oe_out) |-> so_out == last_cmd_out[7])
    else $error("first status bit wrong");
  // command register only moves after select has gone high
  AST_CMD_HOLD: assert property (!$stable(last_cmd_out) |-> cs_n_in && $past(cs_n_in, 3))
    else $error("command changed inside frame");
  // a channel 1 high overcurrent event outside a frame raises the fault pin
  AST_PIN_SET: assert property ($rose(chan_fault_in[1].oc_high) && cs_n_in
    |-> ##[1:8] fault_indicator_pin_out)
    else $error("fault pin not raised");
endmodule // ssr_monitor

bind ssr_status_readback ssr_monitor u_mon (.clk_sys_in, .sys_rst_in, .sclk_in, .cs_n_in,
  .so_out, .so_oe_out, .chan_fault_in, .fault_indicator_pin_out, .last_cmd_out);

// ==== verif/ssr_host_model.sv ====
// host side of the serial link: a master framing bytes msb first
// runs off the bench clock; serial clock half period is four clocks
`timescale 1ns/1ps

module ssr_host_model (
  input  wire logic  clk_in,        // bench clock
  input  wire logic  so_in,         // device serial out
  input  wire logic  so_oe_in,      // device drives so
  output logic       sclk_out,      // serial clock, idles low
  output logic       cs_n_out,      // chip select, low active
  output logic       si_out,        // serial data to device
  output logic [7:0] byte_out,      // last byte taken from so
  output logic       byte_stb_out   // one cycle when a byte completes
);
  logic [7:0] rx = 8'h00;  // bits taken so far
  logic       line;        // so as seen on the wire
  // released line shows the inverse of the last bit, never a stale copy
  assign line = so_oe_in ? so_in : ~rx[0];
  initial
  begin
    {sclk_out, si_out, byte_out, byte_stb_out} = '0;
    cs_n_out = 1'b1;
  end
  // one frame of n bits taken from the top of d
  task automatic xfer(input logic [15:0] d, input int n);
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    si_out   <= d[15];
    repeat (8) @(posedge clk_in);
    for (int i = 0; i < n; i++)
    begin
      sclk_out     <= 1'b1;                 // rising edge: both sides sample
      rx           <= {rx[6:0], line};
      byte_out     <= {rx[6:0], line};
      byte_stb_out <= (i % 8 == 7);         // every byte kept: no supply dip or wake
      @(posedge clk_in);
      byte_stb_out <= 1'b0;
      repeat (3) @(posedge clk_in);
      sclk_out <= 1'b0;                     // falling edge: data moves
      si_out   <= (i < 15) ? d[14 - i] : 1'b0;
      repeat (4) @(posedge clk_in);
    end
    cs_n_out <= 1'b1;
    si_out   <= ~si_out;                    // idle data is not a held copy
    repeat (8) @(posedge clk_in);
  endtask
endmodule // ssr_host_model

// ==== verif/tb.sv ====
// top bench for the serial status readback block
// host model runs the link; expected bytes wait in a queue
`timescale 1ns/1ps

module tb;
  import ssr_pkg::*;
  logic clk_sys_in = 1'b0;  // 10 MHz clock
  logic sys_rst_in = 1'b1;  // held for eight cycles
  logic sclk, cs_n, si, so, so_oe, fpin, stb;
  logic dir_on = 1'b0, in1 = 1'b0, in0 = 1'b0, failsafe_select_pin = 1'b0, wake = 1'b0, wdx = 1'b0;
  logic [1:0] fss = 2'h0;
  logic [7:0] lcmd, rxb;
  ssr_chan_fault_s [1:0] flt = '0;
  logic [7:0] exp_q[$], msk_q[$];  // expected bytes and care masks
  logic [31:0] lfsr = 32'h7d7ca020;
  int fails = 0, checks_done = 0;

  always #50 clk_sys_in = ~clk_sys_in;

  ssr_status_readback dut (.clk_sys_in, .sys_rst_in, .sclk_in(sclk), .cs_n_in(cs_n),
    .si_in(si), .so_out(so), .so_oe_out(so_oe), .chan_fault_in(flt), .undervoltage_in(1'b0),
    .overvoltage_in(1'b0), .direct_on_in(dir_on), .in1_pin_in(in1), .in0_pin_in(in0),
    .failsafe_select_pin_in(failsafe_select_pin), .wake_pin_in(wake), .watchdog_expired_in(wdx),
    .failsafe_state_in(fss), .fault_indicator_pin_out(fpin), .last_cmd_out(lcmd));
  ssr_host_model host (.clk_in(clk_sys_in), .so_in(so), .so_oe_in(so_oe), .sclk_out(sclk),
    .cs_n_out(cs_n), .si_out(si), .byte_out(rxb), .byte_stb_out(stb));

  // compare and count
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // note the expected bytes, then run the frame
  task automatic frame(input logic [15:0] d, input int n, input logic [7:0] e,
                       input logic [7:0] m);
    if (n >= 8) begin exp_q.push_back(e); msk_q.push_back(m); end
    if (n == 16) begin exp_q.push_back(d[15:8]); msk_q.push_back(8'hff); end
    host.xfer(d, n);
  endtask
  // one step of the bench's feedback shift register
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // new random levels on the live pins and fail-safe inputs
  task automatic rnd_pins();
    @(posedge clk_sys_in);
    lfsr = lfsr_next(lfsr);
    {in1, in0, failsafe_select_pin, wake, wdx, fss} <= lfsr[6:0];
    @(posedge clk_sys_in);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // watcher: each completed byte takes the oldest note
  always @(posedge clk_sys_in)
    if (stb === 1'b1)
    begin
      if (exp_q.size() == 0) begin exp_q.push_back(~rxb); msk_q.push_back(8'hff); end
      check(rxb & msk_q[0], exp_q[0] & msk_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end

  // main sequence
  initial
  begin
    repeat (8) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    frame(16'ha525, 16, 8'h70, 8'hf7);
    frame(16'h0200, 8, 8'h70, 8'hf7);
    frame(16'h3100, 8, 8'h25, 8'hff);
    frame(16'h0000, 7, 8'h00, 8'h00);
    check(lcmd, 8'h31);
    frame(16'h0300, 8, 8'h25, 8'hff);
    frame(16'hd600, 8, 8'h31, 8'hff);
    frame(16'h8500, 8, 8'hb1, 8'hff);
    rnd_pins();
    frame(16'he000, 8, {4'hd, fss[1], wdx, 2'b10}, 8'hff);
    frame(16'h0600, 8, {4'hd, fss[1], wdx, 2'b10}, 8'hff);
    rnd_pins();
    frame(16'h0000, 8, {4'h6, in1, in0, failsafe_select_pin, wake}, 8'hff);
    flt[1].oc_high <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    flt[1].oc_high <= 1'b0;
    repeat (10) @(posedge clk_sys_in);
    frame(16'h8000, 8, 8'h01, 8'hff);
    frame(16'h6000, 8, 8'ha0, 8'hff);
    check({7'h00, fpin}, 8'h01);
    dir_on <= 1'b1;
    @(posedge clk_sys_in);
    dir_on <= 1'b0;
    repeat (10) @(posedge clk_sys_in);
    check({7'h00, fpin}, 8'h00);
    frame(16'h9500, 8, 8'h00, 8'hff);
    frame(16'h0100, 8, 8'h80, 8'hff);
    frame(16'he300, 8, 8'h15, 8'hff);
    frame(16'h0400, 8, 8'h95, 8'hff);
    frame(16'h4900, 8, 8'h40, 8'hff);
    frame(16'h0600, 8, 8'h49, 8'hff);
    frame(16'hd700, 8, {4'h6, in1, in0, failsafe_select_pin, wake}, 8'hff);
    frame(16'h0500, 8, 8'he3, 8'hff);
    frame(16'h5300, 8, {4'h5, fss[0], 3'h0}, 8'hff);
    frame(16'h0000, 8, {4'h5, fss[0], 3'h3}, 8'hff);
    check(8'(exp_q.size()), 8'h00);
    wrap_up();
  end

  // watchdog against a hung link
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    fails++;
    wrap_up();
  end
endmodule // tb
